// ### logic/mis_core.sv
// Instruction sequencer core: fetch, decode and execute of the 8-bit controller
`timescale 1ns/10ps
`default_nettype none
module mis_core #(
  parameter int OSC_START_CYC = 1024
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program memory bus
  output logic [mis_pkg::PC_W-1:0] progAddr,
  input wire logic [7:0] progData,
  output logic busEarly,
  output logic busRom,
  // Data space bus
  output logic [7:0] dsAddr,
  input wire logic [7:0] dsRdData,
  output logic [7:0] dsWrData,
  output logic dsWe,
  input wire logic [5:0] romPage,
  // Interrupt and oscillator control
  input wire logic irqReq,
  input wire logic [1:0] irqSrc,
  output logic irqAck,
  output logic inIrq,
  output logic oscStop,
  output logic coreWait,
  // Core state
  output logic [7:0] acc
);
  import mis_pkg::*;

  typedef enum {ST_RUN, ST_IRQ, ST_HALT, ST_WAKE, ST_SLEEP} mis_state_t;

  localparam logic [15:0] WAKE_LAST = 16'(OSC_START_CYC + OSC_EXTRA_CYC - 1);

  // ==========================================================
  // Decode helpers
  function automatic mis_cls_t classify(input logic [7:0] op);
    mis_cls_t c;
    c = C_NOP;
    if (!op[0]) begin
      c = C_RELBR;
    end else begin
      case (op[3:0])
        LO_CALL: c = C_CALL;
        LO_UBR: c = C_UBR;
        LO_BITBR: c = C_BITBR;
        LO_IMM: begin
          if (!op[4]) begin
            c = C_IND;
          end else if (mis_alu_t'(op[7:5]) inside {ALU_PLUS_ONE, ALU_STORE, ALU_MINUS_ONE}) begin
            c = C_NOP;
          end else begin
            c = C_IMM;
          end
        end
        LO_DIR: c = op[4] ? C_DIR : C_IND;
        LO_SDINC: c = op[4] ? C_SHD : C_NOP;
        LO_SDDEC: begin
          if (op[4]) begin
            c = C_SHD;
          end else begin
            case (op)
              OP_MOVE_RR: c = C_MOVR;
              OP_INVERT: c = C_INV;
              OP_IRQ_EXIT: c = C_IRQX;
              OP_HALT: c = C_HALT;
              OP_ROTATE: c = C_ROT;
              OP_SUB_EXIT: c = C_SUBX;
              OP_WAIT: c = C_WAIT;
              default: c = C_NOP;
            endcase
          end
        end
        default: c = C_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [2:0] lastOf(input mis_cls_t c);
    case (c)
      C_RELBR, C_SUBX, C_IRQX, C_HALT, C_WAIT, C_NOP: return CYC_SHORT;
      C_BITBR: return CYC_BITTEST;
      default: return CYC_LONG;
    endcase
  endfunction

  function automatic logic [11:0] lenOf(input mis_cls_t c);
    case (c)
      C_IMM, C_DIR: return 12'h002;
      C_MOVR, C_BITBR: return 12'h003;
      default: return 12'h001;
    endcase
  endfunction

  function automatic mis_alu_t shdAlu(input logic [7:0] op);
    case ({op[3], op[5]})
      2'b00: return ALU_PLUS_ONE;
      2'b01: return ALU_MOVE;
      2'b10: return ALU_MINUS_ONE;
      default: return ALU_STORE;
    endcase
  endfunction

  function automatic logic inWin(input logic [7:0] a);
    return a[7:6] == WIN_PAGE;
  endfunction

  function automatic logic isIdx(input logic [7:0] a);
    return a[7:2] == IDX_PAGE;
  endfunction

  // ==========================================================
  // State
  mis_state_t state, next_state;
  logic [2:0] cyc, next_cyc;
  logic [15:0] wakeCnt, next_wakeCnt;
  logic [11:0] pc, next_pc, next_addr, stackTop, vector;
  logic [7:0] opReg, byte2, opnd, curOp, rdVal, aluB, aluRes, wrAddr, wrData;
  logic [7:0] idx [4];
  logic [1:0] zBank, cBank;
  logic romNext, lastCyc, irqTake, aluC, curZ, curC, newZ, newC, updZ, updC;
  logic wrGo, push, pop, bitVal, isAlu, isAccOp;
  logic [11:0] pushData;
  mis_cls_t cls;
  mis_alu_t effOp;

  mis_ret_stack uStack (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(push),
    .pop(pop),
    .pushData(pushData),
    .top(stackTop)
  );

  always_comb begin
    curOp = (cyc == CYC_FIRST) ? progData : opReg;
    cls = classify(curOp);
    lastCyc = (cyc == lastOf(cls));
    irqTake = irqReq && !inIrq;
    curZ = zBank[inIrq];
    curC = cBank[inIrq];
    isAlu = cls inside {C_IMM, C_DIR, C_IND, C_SHD};
    isAccOp = cls inside {C_INV, C_ROT};
    effOp = (cls == C_SHD) ? shdAlu(curOp) : mis_alu_t'(curOp[7:5]);
    bitVal = opnd[{curOp[5], curOp[6], curOp[7]}];
    vector = VEC_BASE + {9'h000, irqSrc, 1'b0};
    if (dsAddr == ADR_ACC) begin
      rdVal = acc;
    end else if (isIdx(dsAddr)) begin
      rdVal = idx[dsAddr[1:0]];
    end else begin
      rdVal = dsRdData;
    end
  end

  // ==========================================================
  // Arithmetic and logic
  always_comb begin
    aluB = ((cls == C_DIR || cls == C_IND) && inWin(dsAddr)) ? progData : opnd;
    aluRes = aluB;
    aluC = curC;
    unique case (effOp)
      ALU_MOVE: aluRes = aluB;
      ALU_COMPARE, ALU_SUBTRACT: begin
        aluRes = acc - aluB;
        aluC = acc < aluB;
      end
      ALU_SUM: {aluC, aluRes} = {1'b0, acc} + {1'b0, aluB};
      ALU_PLUS_ONE: aluRes = aluB + 8'h01;
      ALU_STORE: aluRes = acc;
      ALU_CONJ: aluRes = acc & aluB;
      ALU_MINUS_ONE: aluRes = aluB - 8'h01;
    endcase
    if (cls == C_INV) begin
      aluRes = ~acc;
      aluC = acc[7];
    end else if (cls == C_ROT) begin
      aluRes = {acc[6:0], curC};
      aluC = acc[7];
    end
  end

  // ==========================================================
  // Write-back and flag selection
  always_comb begin
    wrGo = 1'b0;
    wrAddr = ADR_ACC;
    wrData = aluRes;
    updZ = 1'b0;
    updC = 1'b0;
    newZ = (aluRes == 8'h00);
    newC = aluC;
    if (state == ST_RUN) begin
      if (cls == C_MOVR && cyc == CYC_THIRD) begin
        wrGo = !inWin(dsAddr);
        wrAddr = dsAddr;
        wrData = progData;
      end else if (lastCyc && (isAlu || isAccOp)) begin
        wrGo = isAccOp || effOp != ALU_COMPARE;
        wrAddr = (isAccOp || effOp inside {ALU_MOVE, ALU_SUM, ALU_CONJ, ALU_SUBTRACT})
                 ? ADR_ACC : dsAddr;
        updZ = 1'b1;
        updC = isAccOp || effOp inside {ALU_COMPARE, ALU_SUM, ALU_SUBTRACT};
      end else if (lastCyc && cls == C_BITBR) begin
        updC = 1'b1;
        newC = bitVal;
      end
    end
  end

  // ==========================================================
  // Program counter and stack control
  always_comb begin
    next_pc = pc + lenOf(cls);
    push = 1'b0;
    pop = 1'b0;
    pushData = pc;
    unique case (cls)
      C_CALL, C_UBR: next_pc = {byte2, curOp[7:4]};
      C_RELBR: begin
        if ((curOp[1] ? curC : curZ) == curOp[2]) begin
          next_pc = pc + 12'h001 + {{7{curOp[7]}}, curOp[7:3]};
        end
      end
      C_BITBR: begin
        if (bitVal == curOp[4]) begin
          next_pc = pc + 12'h003 + {{4{byte2[7]}}, byte2};
        end
      end
      C_SUBX, C_IRQX: next_pc = stackTop;
      default: next_pc = pc + lenOf(cls);
    endcase
    if (state == ST_RUN && cls == C_CALL && cyc == CYC_THIRD) begin
      push = 1'b1;
      pushData = pc + 12'h002;
    end else if (state == ST_IRQ) begin
      push = 1'b1;
    end
    pop = state == ST_RUN && lastCyc && (cls == C_SUBX || cls == C_IRQX);
  end

  // ==========================================================
  // Sequencing
  always_comb begin
    next_state = state;
    next_cyc = cyc;
    next_wakeCnt = wakeCnt;
    unique case (state)
      ST_RUN: begin
        if (!lastCyc) begin
          next_cyc = cyc + 3'h1;
        end else begin
          next_cyc = CYC_FIRST;
          // halt or suspend after two cycles
          if (cls == C_HALT) begin
            next_state = ST_HALT;
          end else if (cls == C_WAIT) begin
            next_state = ST_SLEEP;
          end else if (irqTake) begin
            next_state = ST_IRQ;
          end
        end
      end
      ST_IRQ: next_state = ST_RUN;
      ST_HALT: begin
        if (irqReq) begin
          next_state = ST_WAKE;
          next_wakeCnt = 16'h0000;
        end
      end
      ST_WAKE: begin
        if (wakeCnt == WAKE_LAST) begin
          next_state = inIrq ? ST_RUN : ST_IRQ;
        end else begin
          next_wakeCnt = wakeCnt + 16'h0001;
        end
      end
      ST_SLEEP: begin
        if (irqReq) begin
          next_state = inIrq ? ST_RUN : ST_IRQ;
        end
      end
    endcase
  end

  // Address driven in the coming cycle
  always_comb begin
    next_addr = pc + 12'h001;
    romNext = 1'b0;
    if (state == ST_IRQ) begin
      next_addr = vector;
    end else if (state != ST_RUN) begin
      next_addr = pc;
    end else if (lastCyc) begin
      next_addr = next_pc;
    end else begin
      case (cyc)
        CYC_FIRST: next_addr = (cls == C_SUBX || cls == C_IRQX) ? stackTop : pc + 12'h001;
        CYC_SECOND: begin
          if (cls == C_BITBR && inWin(progData)) begin
            next_addr = {romPage, progData[5:0]};
            romNext = 1'b1;
          end else if (cls == C_MOVR || cls == C_BITBR) begin
            next_addr = pc + 12'h002;
          end
        end
        CYC_THIRD: begin
          // ROM window replaces next opcode address
          if ((cls == C_MOVR || cls == C_DIR || cls == C_IND) && inWin(dsAddr)) begin
            next_addr = {romPage, dsAddr[5:0]};
            romNext = 1'b1;
          end else if (cls == C_MOVR) begin
            next_addr = pc + 12'h003;
          end else if (cls inside {C_IMM, C_DIR, C_CALL, C_UBR, C_BITBR}) begin
            next_addr = pc + 12'h002;
          end
        end
        CYC_FOURTH: next_addr = pc + 12'h003;
        default: next_addr = pc + 12'h001;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      cyc <= CYC_FIRST;
      wakeCnt <= 16'h0000;
    end else begin
      state <= next_state;
      cyc <= next_cyc;
      wakeCnt <= next_wakeCnt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      progAddr <= RESET_PC;
      busEarly <= 1'b1;
      busRom <= 1'b0;
    end else begin
      progAddr <= next_addr;
      busEarly <= next_state == ST_RUN && next_cyc == CYC_FIRST;
      busRom <= romNext;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc <= RESET_PC;
    end else if (state == ST_IRQ) begin
      pc <= vector;
    end else if (state == ST_RUN && lastCyc) begin
      pc <= next_pc;
    end
  end

  // ==========================================================
  // Operand capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      opReg <= 8'h00;
      byte2 <= 8'h00;
      opnd <= 8'h00;
      dsAddr <= 8'h00;
    end else if (state == ST_RUN) begin
      if (cyc == CYC_FIRST) begin
        opReg <= progData;
      end
      if (cyc == CYC_SECOND) begin
        unique case (cls)
          C_DIR, C_MOVR, C_BITBR: dsAddr <= progData;
          C_IND: dsAddr <= curOp[3] ? idx[1] : idx[0];
          C_SHD: dsAddr <= {IDX_PAGE, curOp[7:6]};
          C_INV, C_ROT: dsAddr <= ADR_ACC;
          default: dsAddr <= dsAddr;
        endcase
      end
      if (cyc == CYC_THIRD) begin
        opnd <= (cls == C_IMM || (cls == C_BITBR && inWin(dsAddr))) ? progData : rdVal;
        if (cls == C_CALL || cls == C_UBR) begin
          byte2 <= progData;
        end
      end
      if (cyc == CYC_FOURTH && cls == C_BITBR) begin
        byte2 <= progData;
      end
    end
  end

  // ==========================================================
  // Registers and data space writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        idx[i] <= 8'h00;
      end
    end else if (wrGo) begin
      if (wrAddr == ADR_ACC) begin
        acc <= wrData;
      end else if (isIdx(wrAddr)) begin
        idx[wrAddr[1:0]] <= wrData;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dsWe <= 1'b0;
      dsWrData <= 8'h00;
    end else begin
      dsWe <= wrGo && wrAddr != ADR_ACC && !isIdx(wrAddr) && !inWin(wrAddr);
      dsWrData <= wrData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zBank <= 2'b00;
      cBank <= 2'b00;
    end else begin
      if (updZ) begin
        zBank[inIrq] <= newZ;
      end
      if (updC) begin
        cBank[inIrq] <= newC;
      end
    end
  end

  // ==========================================================
  // Interrupt and oscillator state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inIrq <= 1'b0;
      irqAck <= 1'b0;
      oscStop <= 1'b0;
      coreWait <= 1'b0;
    end else begin
      irqAck <= state == ST_IRQ;
      if (state == ST_IRQ) begin
        inIrq <= 1'b1;
      end else if (pop && cls == C_IRQX) begin
        inIrq <= 1'b0;
      end
      oscStop <= next_state == ST_HALT;
      coreWait <= next_state == ST_SLEEP;
    end
  end
endmodule
`default_nettype wire

// ### logic/mis_pkg.sv
// Constants and types for the 8-bit instruction sequencer
//
// Behaviour
// - Immediate ALU, compare and load take four cycles: decode, idle, read operand, execute.
// - Immediate register load: decode, fetch address byte, fetch data, write register.
// - Register load aimed at ROM window drives ROM address in fourth cycle.
// - Short-direct ops take four cycles, address from opcode, bus at opcode plus one.
// - Early-flagged bus values valid at cycle start; ROM-window values only until t18.
// - Subroutine jump: decode, bump stack pointer, push return, form 12-bit target.
// - Accumulator complement: decode, form accumulator address, read, write inverse; four cycles.
// - Interrupt entry takes one cycle: vector, push next address, switch flag set.
// - After halt, interrupt entry waits oscillator start-up plus 16 clocks.
// - Absolute jump: decode, idle, read address byte, load 12-bit target; four cycles.
// - Carry or zero relative branches take two cycles using the 5-bit offset.
// - Bit-test branches: decode, read operand, test bit, fetch displacement, branch; five cycles.
// - Subroutine and interrupt exit pop return in two cycles; interrupt exit restores flags.
// - Halt and wait take two cycles, then stop the oscillator or suspend the core.
// - Register addition adds source to accumulator; prefix 5F, indirect 47 and 4F.
// - Sum sets zero on zero result, carry on overflow out of eight bits.
// - Immediate sum, opcode 57 plus data, adds byte into accumulator.
// - Conjunction into accumulator, zero flag only; prefix BF, indirect A7 and AF.
// - Immediate conjunction, opcode B7 plus data, zero flag only, carry kept.
// - Subroutine jump pushes program counter plus two and loads target from opcode nibble and byte.
// - Return stack six deep; overflow loses newest entries, returns reach the oldest.
// - Clear writes zero; accumulator form sets zero, resets carry; three-byte form keeps flags.
package mis_pkg;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam logic [2:0] STACK_FULL = 3'h6;
  localparam logic [11:0] RESET_PC = 12'h000;
  localparam logic [11:0] VEC_BASE = 12'hff0;
  localparam logic [7:0] ADR_ACC = 8'hff;
  localparam logic [5:0] IDX_PAGE = 6'h20;
  localparam logic [1:0] WIN_PAGE = 2'h1;
  localparam int OSC_EXTRA_CYC = 16;
  localparam logic [2:0] CYC_FIRST = 3'h1;
  localparam logic [2:0] CYC_SECOND = 3'h2;
  localparam logic [2:0] CYC_THIRD = 3'h3;
  localparam logic [2:0] CYC_FOURTH = 3'h4;
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_LONG = 3'h4;
  localparam logic [2:0] CYC_BITTEST = 3'h5;
  localparam logic [3:0] LO_CALL = 4'h1;
  localparam logic [3:0] LO_UBR = 4'h9;
  localparam logic [3:0] LO_BITBR = 4'h3;
  localparam logic [3:0] LO_IMM = 4'h7;
  localparam logic [3:0] LO_DIR = 4'hf;
  localparam logic [3:0] LO_SDINC = 4'h5;
  localparam logic [3:0] LO_SDDEC = 4'hd;
  localparam logic [7:0] OP_MOVE_RR = 8'h0d;
  localparam logic [7:0] OP_INVERT = 8'h2d;
  localparam logic [7:0] OP_IRQ_EXIT = 8'h4d;
  localparam logic [7:0] OP_HALT = 8'h6d;
  localparam logic [7:0] OP_ROTATE = 8'had;
  localparam logic [7:0] OP_SUB_EXIT = 8'hcd;
  localparam logic [7:0] OP_WAIT = 8'hed;
  typedef enum logic [2:0] {
    ALU_MOVE, ALU_COMPARE, ALU_SUM, ALU_PLUS_ONE,
    ALU_STORE, ALU_CONJ, ALU_SUBTRACT, ALU_MINUS_ONE
  } mis_alu_t;
  typedef enum logic [3:0] {
    C_NOP, C_IMM, C_MOVR, C_SHD, C_DIR, C_IND, C_CALL, C_UBR,
    C_RELBR, C_BITBR, C_INV, C_ROT, C_SUBX, C_IRQX, C_HALT, C_WAIT
  } mis_cls_t;
endpackage

// ### logic/mis_ret_stack.sv
// Six-level hardware return stack
`timescale 1ns/10ps
`default_nettype none
module mis_ret_stack (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [mis_pkg::PC_W-1:0] pushData,
  output logic [mis_pkg::PC_W-1:0] top
);
  import mis_pkg::*;

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [2:0] depth;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth <= 3'h0;
    end else if (push && depth != STACK_FULL) begin
      depth <= depth + 3'h1;
    end else if (pop && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : gLevel
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          mem[g] <= '0;
        end else if (push && depth == 3'(g)) begin
          mem[g] <= pushData;
        end
      end
    end
  endgenerate

  // Empty stack returns the oldest slot
  always_comb begin
    top = (depth == 3'h0) ? mem[0] : mem[depth - 3'h1];
  end
endmodule
`default_nettype wire

// ### tb/mis_core_monitor.sv
// Checker for the sequencer core ports
`timescale 1ns/10ps
`default_nettype none
module mis_core_monitor #(
  parameter int OSC_START_CYC = 1024
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program and data buses
  input wire logic [mis_pkg::PC_W-1:0] progAddr,
  input wire logic [7:0] progData,
  input wire logic busEarly,
  input wire logic busRom,
  input wire logic [7:0] dsAddr,
  input wire logic [7:0] dsWrData,
  input wire logic dsWe,
  input wire logic [5:0] romPage,
  // Interrupt and core state
  input wire logic irqAck,
  input wire logic inIrq,
  input wire logic [7:0] acc
);
  import mis_pkg::*;
  logic [3:0] opHi;
  assign opHi = progData[7:4];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Sequencing
  // immediate timing
  AST_IMM_SEQ: assert property (
    busEarly && progData inside {8'h57, 8'hb7} |=> !busEarly && progAddr == $past(progAddr) + 12'h1
    ##1 !busEarly && $stable(progAddr) ##1 !busEarly && progAddr == $past(progAddr) + 12'h1
    ##1 busEarly) else $error("immediate sequence wrong");
  AST_SUM_ACC: assert property (
    busEarly && progData == 8'h57 |=> $stable(acc) [*3]
    ##1 acc == $past(acc, 4) + $past(progData, 2)) else $error("sum result wrong");
  AST_CONJ_ACC: assert property (
    busEarly && progData == 8'hb7 |=> $stable(acc) [*3]
    ##1 acc == ($past(acc, 4) & $past(progData, 2))) else $error("conjunction result wrong");
  AST_INV_ACC: assert property (
    busEarly && progData == OP_INVERT |=> $stable(acc) [*3]
    ##1 acc == ~$past(acc, 4)) else $error("complement result wrong");
  AST_CLR_ACC: assert property (
    busEarly && progData == 8'hdf ##1 progData == 8'hff |=> $stable(acc) [*2]
    ##1 acc == 8'h00) else $error("accumulator clear wrong");
  AST_XFER_SEQ: assert property (
    busEarly && progData[2:0] == 3'h1 |-> ##4 busEarly
    && progAddr == {$past(progData, 2), $past(opHi, 4)}) else $error("call or jump target wrong");
  AST_REL_LEN: assert property (
    busEarly && !progData[0] |=> !busEarly ##1 busEarly) else $error("relative branch length wrong");
  AST_IRQX_BANK: assert property (
    busEarly && progData == OP_IRQ_EXIT && inIrq |=> !busEarly ##1 busEarly && !inIrq)
    else $error("interrupt exit wrong");
  AST_ACK_ENTRY: assert property (
    irqAck |-> inIrq && progAddr[11:3] == 9'h1fe && !progAddr[0] ##1 !irqAck)
    else $error("interrupt entry wrong");
  AST_ROM_ADDR: assert property (
    busRom |-> !busEarly && progAddr == {romPage, dsAddr[5:0]}) else $error("window address wrong");
  AST_MOVE_WR: assert property (
    busEarly && progData == OP_MOVE_RR |-> ##3 dsAddr == $past(progData, 2)
    && dsWe == !($past(progData, 2) inside {[8'h40:8'h83], 8'hff})
    && dsWrData == $past(progData) ##1 busEarly && !dsWe) else $error("register load wrong");
endmodule
bind mis_core mis_core_monitor #(.OSC_START_CYC(OSC_START_CYC)) chk (.ref_clk(ref_clk),
  .rst(rst), .progAddr(progAddr), .progData(progData), .busEarly(busEarly), .busRom(busRom),
  .dsAddr(dsAddr), .dsWrData(dsWrData), .dsWe(dsWe), .romPage(romPage), .irqAck(irqAck),
  .inIrq(inIrq), .acc(acc));
`default_nettype wire

// ### tb/mis_prog_mem.sv
// Program memory and data space model
`timescale 1ns/10ps
`default_nettype none
module mis_prog_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program bus
  input wire logic [mis_pkg::PC_W-1:0] progAddr,
  output logic [7:0] progData,
  // Data space bus
  input wire logic [7:0] dsAddr,
  output logic [7:0] dsRdData,
  input wire logic [7:0] dsWrData,
  input wire logic dsWe
);
  import mis_pkg::*;
  logic [7:0] prog [4096];
  logic [7:0] ram [256];
  // ==========
  // Read paths, window bytes too
  assign progData = prog[progAddr];
  assign dsRdData = ram[dsAddr];
  // ==========
  // Data space writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) ram[i] <= 8'h00;
    end else if (dsWe) begin
      ram[dsAddr] <= dsWrData;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Random and corner programs run through the sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mis_pkg::*;
  localparam int OSC = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic irqReq = 1'b0;
  logic [1:0] irqSrc = 2'h0;
  logic [5:0] romPage = 6'h00;
  logic [11:0] progAddr;
  logic [7:0] progData, dsAddr, dsRdData, dsWrData, acc;
  logic busEarly, busRom, dsWe, irqAck, inIrq, oscStop, coreWait;
  int fails = 0;
  int compares = 0;

  mis_core #(.OSC_START_CYC(OSC)) uut (.ref_clk(ref_clk), .rst(rst), .progAddr(progAddr),
    .progData(progData), .busEarly(busEarly), .busRom(busRom), .dsAddr(dsAddr),
    .dsRdData(dsRdData), .dsWrData(dsWrData), .dsWe(dsWe), .romPage(romPage),
    .irqReq(irqReq), .irqSrc(irqSrc), .irqAck(irqAck), .inIrq(inIrq), .oscStop(oscStop),
    .coreWait(coreWait), .acc(acc));
  mis_prog_mem mem (.ref_clk(ref_clk), .rst(rst), .progAddr(progAddr), .progData(progData),
    .dsAddr(dsAddr), .dsRdData(dsRdData), .dsWrData(dsWrData), .dsWe(dsWe));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait, cycles counted in n
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    // Limit ran out
    if (s !== 1'b1) begin
      fails++;
      $display("mismatch wait expected 1 seen %b", s);
    end
  endtask

  // Carry decides whether the plus-one step is skipped
  function automatic logic [7:0] exp_acc(input logic [7:0] a, b, c);
    logic [8:0] s;
    logic [7:0] x;
    s = {1'b0, a & b} + {1'b0, c};
    x = s[7:0] + {7'h00, !s[8]} + 8'h10;
    // Register sequence in the subroutine ends at twice plus one
    return {x[6:0], 1'b1};
  endfunction

  initial begin
    #100000;
    fails++;
    test_done();
  end

  // ==========
  // Main sequence
  initial begin
    logic [7:0] a, b, c, r, d;
    logic [1:0] v;
    logic [7:0] prog [32];
    int n;
    void'($urandom(11));
    for (int i = 0; i < 4096; i++) mem.prog[i] = 8'h04;
    for (int i = 0; i < 4; i++) mem.prog[VEC_BASE + 12'(2 * i)] = OP_IRQ_EXIT;
    for (int t = 0; t < 8; t++) begin
      a = t == 0 ? 8'hff : 8'($urandom);
      b = t < 2 ? {8{t == 0}} : 8'($urandom);
      c = t < 2 ? {7'h00, t == 0} : 8'($urandom);
      r = t < 2 ? 8'h3f + 8'(t) : 8'($urandom_range(127));
      d = 8'($urandom);
      v = 2'($urandom);
      rst = 1'b1;
      romPage = 6'($urandom);
      // Subroutine also runs clear, complement and register forms
      prog = '{8'h57, a, 8'hb7, b, 8'h57, c, 8'h16, 8'h57, 8'h01, 8'h01, 8'h10,
        t[0] ? OP_WAIT : OP_HALT, 8'hb9, 8'h00, OP_MOVE_RR, r, d, 8'h57, 8'h10,
        8'h3d, 8'hdf, 8'hff, 8'h35, OP_INVERT, 8'h5f, 8'h80, 8'hbf, 8'h80, 8'h15,
        8'h5f, 8'h80, OP_SUB_EXIT};
      for (int i = 0; i < 32; i++) mem.prog[i < 14 ? i : i + 242] = prog[i];
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      if (t[0]) wait_hi(coreWait, n);
      else wait_hi(oscStop, n);
      check("acc", {4'h0, exp_acc(a, b, c)}, {4'h0, acc});
      check("data", {4'h0, r < 8'h40 ? d : 8'h00}, {4'h0, mem.ram[r]});
      irqSrc = v;
      irqReq = 1'b1;
      wait_hi(irqAck, n);
      irqReq = 1'b0;
      check("vector", VEC_BASE + {9'h000, v, 1'b0}, progAddr);
      check("wake", 12'h001, {11'h000, t[0] ? n < 4 : n inside {[OSC + 16:OSC + 19]}});
      repeat (2) @(negedge ref_clk);
      if (t[0]) wait_hi(coreWait, n);
      else wait_hi(oscStop, n);
      check("bank", 12'h000, {11'h000, inIrq});
      check("stopped", 12'h001, {11'h000, oscStop | coreWait});
    end
    test_done();
  end
endmodule
`default_nettype wire
